// [verilog/ajc_top.sv]
// autonomous job control port with wishbone register access
`timescale 1ns/1ns
`include "ajc_map.svh"

module ajc_top #(
  parameter int          SITES        = `AJC_SITES,
  parameter int unsigned HOLD_CYCLES  = `AJC_HOLD_MS * `AJC_CLK_KHZ,
  parameter int unsigned BLINK_CYCLES = `AJC_BLINK_MS * `AJC_CLK_KHZ
) (
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               autonomous_entry_pin,
  input  wire logic               start_n,
  input  wire logic [2*SITES-1:0] job_sel,
  output logic                    prog_start,
  output logic      [3*SITES-1:0] prog_job,
  input  wire logic               prog_done,
  input  wire logic               prog_ok,
  output logic                    busy_n,
  output logic                    pass_n,
  output logic                    fail_n,
  output logic                    led_yellow,
  output logic                    led_green,
  output logic                    led_red,
  output logic                    irq
);

  ajc_pkg::ajc_mode_e          mode;
  ajc_pkg::ajc_mode_e          next_mode;
  ajc_pkg::ajc_stat_s          stat;
  logic [31:0]                 hold_cnt;
  logic [31:0]                 blink_cnt;
  logic                        blink_phase;
  logic                        entry_d;
  logic                        start_d;
  logic                        hold_done;
  logic                        pin_launch;
  logic                        launch;
  logic                        busy;
  logic                        finish;
  logic                        wb_req;
  logic                        wb_wr;
  logic                        wr_ctrl;
  logic                        cmd_host;
  logic                        cmd_auto;
  logic                        cmd_exit;
  logic                        cmd_launch;
  logic [`AJC_EV_W-1:0]        int_status;
  logic [`AJC_EV_W-1:0]        int_enable;
  logic [`AJC_EV_W-1:0]        int_event;
  logic [`AJC_EV_W-1:0]        int_clear;
  logic [31:0]                 next_rdata;

  // bus decode: one access per classic cycle, acked one edge after the request
  assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr      = wb_req & wb_we_i & wb_sel_i[0];
  assign wr_ctrl    = wb_wr & (wb_adr_i == `AJC_ADR_CTRL);
  assign cmd_host   = wr_ctrl & wb_dat_i[`AJC_CTRL_HOST];
  assign cmd_auto   = wr_ctrl & wb_dat_i[`AJC_CTRL_AUTO];
  assign cmd_exit   = wr_ctrl & wb_dat_i[`AJC_CTRL_EXIT];
  assign cmd_launch = wr_ctrl & wb_dat_i[`AJC_CTRL_LAUNCH];
  assign int_clear  = (wb_wr & (wb_adr_i == `AJC_ADR_INT_CLEAR)) ?
                      wb_dat_i[`AJC_EV_W-1:0] : '0;

  // start-line hold timer, saturating
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt <= 32'h0;
    end else if (start_n) begin
      hold_cnt <= 32'h0;
    end else if (hold_cnt < HOLD_CYCLES) begin
      hold_cnt <= hold_cnt + 32'h1;
    end
  end

  assign hold_done = ~start_n & (hold_cnt == HOLD_CYCLES - 1);

  // mode machine
  always_comb begin
    next_mode = mode;
    case (mode)
      ajc_pkg::mode_idle: begin
        if (autonomous_entry_pin | hold_done | cmd_auto) begin
          next_mode = ajc_pkg::mode_auto;
        end else if (cmd_host) begin
          next_mode = ajc_pkg::mode_host;
        end
      end
      ajc_pkg::mode_host: begin
        if (hold_done | cmd_auto) begin
          next_mode = ajc_pkg::mode_auto;
        end
      end
      ajc_pkg::mode_auto: begin
        if (cmd_exit) begin
          next_mode = ajc_pkg::mode_host;
        end
      end
      default: next_mode = ajc_pkg::mode_idle;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode <= ajc_pkg::mode_idle;
    end else begin
      mode <= next_mode;
    end
  end

  // launch edges; levels already present at entry do not launch
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      entry_d <= 1'b0;
      start_d <= 1'b1;
    end else begin
      entry_d <= autonomous_entry_pin;
      start_d <= start_n;
    end
  end

  assign pin_launch = (autonomous_entry_pin & ~entry_d) | (~start_n & start_d);
  assign launch     = ~busy & (((mode == ajc_pkg::mode_auto) & pin_launch) |
                               ((mode == ajc_pkg::mode_host) & cmd_launch));
  assign finish     = busy & prog_done;

  // operation tracking
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
    end else if (launch) begin
      busy <= 1'b1;
    end else if (finish) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stat <= `AJC_STATUS_N_RST;
    end else if (launch) begin
      stat <= '{busy_n: 1'b0, pass_n: 1'b1, fail_n: 1'b1};
    end else if (finish) begin
      stat <= '{busy_n: 1'b1, pass_n: ~prog_ok, fail_n: prog_ok};
    end
  end

  assign busy_n = stat.busy_n;
  assign pass_n = stat.pass_n;
  assign fail_n = stat.fail_n;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prog_start <= 1'b0;
    end else begin
      prog_start <= launch;
    end
  end

  // per-site job capture; pulls make floating lines read 00
  genvar s;
  generate
    for (s = 0; s < SITES; s++) begin : g_site
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          prog_job[3*s +: 3] <= 3'h0;
        end else if (launch) begin
          prog_job[3*s +: 3] <= ajc_pkg::ajc_decode_job(job_sel[2*s +: 2]);
        end
      end
    end
  endgenerate

  // blink timebase runs only while autonomous
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      blink_cnt   <= 32'h0;
      blink_phase <= 1'b0;
    end else if (mode != ajc_pkg::mode_auto) begin
      blink_cnt   <= 32'h0;
      blink_phase <= 1'b0;
    end else if (blink_cnt == BLINK_CYCLES - 1) begin
      blink_cnt   <= 32'h0;
      blink_phase <= ~blink_phase;
    end else begin
      blink_cnt   <= blink_cnt + 32'h1;
    end
  end

  // lamps: a result lights its own lamp steadily, while autonomous the other lamp keeps blinking
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      led_yellow <= 1'b0;
      led_green  <= 1'b0;
      led_red    <= 1'b0;
    end else begin
      led_yellow <= ~stat.busy_n;
      led_green  <= ~stat.pass_n | blink_phase;
      led_red    <= ~stat.fail_n | blink_phase;
    end
  end

  // interrupt status: a set in the clearing cycle wins
  assign int_event[`AJC_EV_ENTER]  = (mode != ajc_pkg::mode_auto) &
                                     (next_mode == ajc_pkg::mode_auto);
  assign int_event[`AJC_EV_LAUNCH] = launch;
  assign int_event[`AJC_EV_PASS]   = finish & prog_ok;
  assign int_event[`AJC_EV_FAIL]   = finish & ~prog_ok;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status & ~int_clear) | int_event;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      int_enable <= `AJC_INT_EN_RST;
    end else if (wb_wr & (wb_adr_i == `AJC_ADR_INT_ENABLE)) begin
      int_enable <= wb_dat_i[`AJC_EV_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_enable);
    end
  end

  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    next_rdata = 32'h0;
    if (wb_adr_i == `AJC_ADR_STATUS) begin
      next_rdata[`AJC_ST_MODE_LSB +: 3] = mode;
      next_rdata[`AJC_ST_BUSY]          = ~stat.busy_n;
      next_rdata[`AJC_ST_PASS]          = ~stat.pass_n;
      next_rdata[`AJC_ST_FAIL]          = ~stat.fail_n;
      next_rdata[`AJC_ST_JOB_LSB +: 3]  = prog_job[2:0];
    end else if (wb_adr_i == `AJC_ADR_INT_STATUS) begin
      next_rdata[`AJC_EV_W-1:0] = int_status;
    end else if (wb_adr_i == `AJC_ADR_INT_ENABLE) begin
      next_rdata[`AJC_EV_W-1:0] = int_enable;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req & ~wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  property p_stay_idle;
    @(posedge clk_sys) disable iff (!reset_n)
      (mode == ajc_pkg::mode_idle) && !autonomous_entry_pin && !hold_done && !wr_ctrl
      |=> (mode == ajc_pkg::mode_idle);
  endproperty
  a_stay_idle: assert property (p_stay_idle) else $error("left idle without cause");

  property p_pin_entry;
    @(posedge clk_sys) disable iff (!reset_n)
      (mode == ajc_pkg::mode_idle) && autonomous_entry_pin |=> (mode == ajc_pkg::mode_auto);
  endproperty
  a_pin_entry: assert property (p_pin_entry) else $error("entry pin ignored in idle");

  property p_hold_entry;
    @(posedge clk_sys) disable iff (!reset_n)
      !start_n && (hold_cnt == HOLD_CYCLES - 1) |=> (mode == ajc_pkg::mode_auto);
  endproperty
  a_hold_entry: assert property (p_hold_entry) else $error("long start hold ignored");

  property p_hold_count;
    @(posedge clk_sys) disable iff (!reset_n)
      !start_n && (hold_cnt < HOLD_CYCLES) |=> start_n || (hold_cnt == $past(hold_cnt) + 1);
  endproperty
  a_hold_count: assert property (p_hold_count) else $error("hold timer did not advance");

  property p_no_blink_out;
    @(posedge clk_sys) disable iff (!reset_n)
      (mode != ajc_pkg::mode_auto) ##1 (mode != ajc_pkg::mode_auto) |-> !blink_phase;
  endproperty
  a_no_blink_out: assert property (p_no_blink_out) else $error("blink outside autonomous");

  property p_blink_lamps;
    @(posedge clk_sys) disable iff (!reset_n)
      blink_phase |=> led_green && led_red;
  endproperty
  a_blink_lamps: assert property (p_blink_lamps) else $error("lamps not lit in blink phase");

  property p_pin_launch;
    @(posedge clk_sys) disable iff (!reset_n)
      (mode == ajc_pkg::mode_auto) && !busy && $rose(autonomous_entry_pin)
      |=> !busy_n ##0 prog_start;
  endproperty
  a_pin_launch: assert property (p_pin_launch) else $error("entry edge did not launch");

  property p_busy_hold;
    @(posedge clk_sys) disable iff (!reset_n)
      !busy_n && !prog_done |=> !busy_n;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy released early");

  property p_pass_hold;
    @(posedge clk_sys) disable iff (!reset_n)
      !pass_n && !launch |=> !pass_n && fail_n;
  endproperty
  a_pass_hold: assert property (p_pass_hold) else $error("pass dropped before launch");

  property p_fail_set;
    @(posedge clk_sys) disable iff (!reset_n)
      busy && prog_done && !prog_ok |=> !fail_n && busy_n && pass_n;
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("failure not flagged");

  property p_lamp_mirror;
    @(posedge clk_sys) disable iff (!reset_n)
      ##1 (led_yellow == !$past(busy_n));
  endproperty
  a_lamp_mirror: assert property (p_lamp_mirror) else $error("yellow lamp not mirroring busy");

  property p_job_map;
    @(posedge clk_sys) disable iff (!reset_n)
      launch && (job_sel[1:0] == 2'b11) |=> (prog_job[2:0] == 3'h4);
  endproperty
  a_job_map: assert property (p_job_map) else $error("code 11 not job 4");

  property p_job_stable;
    @(posedge clk_sys) disable iff (!reset_n)
      !launch |=> $stable(prog_job);
  endproperty
  a_job_stable: assert property (p_job_stable) else $error("job changed without launch");

endmodule

// [verilog/ajc_map.svh]
// register offsets, field positions, reset values and timing counts of the job control port
`ifndef AJC_MAP_SVH
`define AJC_MAP_SVH
`define AJC_ADR_CTRL       8'h00
`define AJC_ADR_STATUS     8'h04
`define AJC_ADR_INT_STATUS 8'h08
`define AJC_ADR_INT_CLEAR  8'h0c
`define AJC_ADR_INT_ENABLE 8'h10
`define AJC_CTRL_HOST      0
`define AJC_CTRL_AUTO      1
`define AJC_CTRL_EXIT      2
`define AJC_CTRL_LAUNCH    3
`define AJC_ST_MODE_LSB    0
`define AJC_ST_BUSY        3
`define AJC_ST_PASS        4
`define AJC_ST_FAIL        5
`define AJC_ST_JOB_LSB     8
`define AJC_EV_ENTER       0
`define AJC_EV_LAUNCH      1
`define AJC_EV_PASS        2
`define AJC_EV_FAIL        3
`define AJC_EV_W           4
`define AJC_INT_EN_RST     4'h0
`define AJC_STATUS_N_RST   3'h7
`define AJC_CLK_KHZ        50000
`define AJC_HOLD_MS        2000
`define AJC_BLINK_MS       250
`define AJC_SITES          2
`endif

// [verilog/ajc_pkg.sv]
// types shared by the job control port
package ajc_pkg;
  typedef enum logic [2:0] {
    mode_idle = 3'b001,
    mode_host = 3'b010,
    mode_auto = 3'b100
  } ajc_mode_e;

  typedef logic [2:0] ajc_job_t;

  // active-low status lines towards the tester
  typedef struct packed {
    logic busy_n;
    logic pass_n;
    logic fail_n;
  } ajc_stat_s;

  function automatic ajc_job_t ajc_decode_job(input logic [1:0] code);
    case (code)
      2'b01:   ajc_decode_job = 3'h1;
      2'b10:   ajc_decode_job = 3'h2;
      2'b11:   ajc_decode_job = 3'h4;
      default: ajc_decode_job = 3'h0;
    endcase
  endfunction
endpackage

// [dv/ajc_engine_model.sv]
// programming engine stand-in that answers each launch after a set delay
`timescale 1ns/1ns

module ajc_engine_model (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       prog_start,
  input  wire logic [7:0] delay,
  input  wire logic       ok,
  output logic            prog_done,
  output logic            prog_ok
);
  logic [7:0] cnt;
  logic       run;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt       <= 8'h00;
      run       <= 1'b0;
      prog_done <= 1'b0;
      prog_ok   <= 1'b0;
    end else begin
      prog_done <= 1'b0;
      // result line carries nothing outside the done pulse, so keep it moving
      prog_ok   <= ~prog_ok;
      if (prog_start) begin
        run <= 1'b1;
        cnt <= delay;
      end else if (run && cnt == 8'h00) begin
        run       <= 1'b0;
        prog_done <= 1'b1;
        prog_ok   <= ok;
      end else if (run) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// [dv/ajc_top_tb.sv]
// self-checking bench of the autonomous job control port
`timescale 1ns/1ns
`include "ajc_map.svh"

module ajc_top_tb;
  localparam int HOLD = 20;
  logic        clk_sys, reset_n, cyc, stb, we, entry, start_n, ok;
  logic        prog_start, prog_done, prog_ok, ack, busy_n, pass_n, fail_n;
  logic        led_y, led_g, led_r, irq;
  logic [7:0]  adr, delay;
  logic [3:0]  sel, job_sel;
  logic [5:0]  prog_job;
  logic [31:0] dat_i, dat_o, q;
  int          n_errors, compares, tg, tr, k;
  int          n_starts = 0;

  ajc_top #(.SITES(2), .HOLD_CYCLES(HOLD), .BLINK_CYCLES(8)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .autonomous_entry_pin(entry), .start_n(start_n), .job_sel(job_sel),
    .prog_start(prog_start), .prog_job(prog_job), .prog_done(prog_done), .prog_ok(prog_ok),
    .busy_n(busy_n), .pass_n(pass_n), .fail_n(fail_n), .led_yellow(led_y),
    .led_green(led_g), .led_red(led_r), .irq(irq));

  ajc_engine_model u_eng (
    .clk_sys(clk_sys), .reset_n(reset_n), .prog_start(prog_start), .delay(delay), .ok(ok),
    .prog_done(prog_done), .prog_ok(prog_ok));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (prog_start === 1'b1) n_starts <= n_starts + 1;
  end

  task results;
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task bound(input int i, input int lim);
    if (i >= lim) begin
      n_errors++;
      $display("unexpected at %0t: wait ran out", $time);
      results();
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (ack === 1'b1) break;
    end
    bound(i, 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  function automatic logic [5:0] exp_job(input logic [3:0] s);
    logic [5:0] r;
    for (int i = 0; i < 2; i++) begin
      case (s[2*i+:2])
        2'b00:   r[3*i+:3] = 3'h0;
        2'b01:   r[3*i+:3] = 3'h1;
        2'b10:   r[3*i+:3] = 3'h2;
        default: r[3*i+:3] = 3'h4;
      endcase
    end
    return r;
  endfunction

  task lamps(input int n);
    logic g0, r0;
    tg = 0;
    tr = 0;
    g0 = led_g;
    r0 = led_r;
    repeat (n) begin
      @(negedge clk_sys);
      if (led_g !== g0) tg++;
      if (led_r !== r0) tr++;
      g0 = led_g;
      r0 = led_r;
    end
  endtask

  task run_job(input logic pin, input logic [3:0] js, input logic okv, input logic [7:0] dl);
    int i;
    @(posedge clk_sys);
    job_sel <= js;
    ok <= okv;
    delay <= dl;
    if (pin) entry <= 1'b1;
    else start_n <= 1'b0;
    for (i = 0; i < 10 && prog_start !== 1'b1; i++) @(negedge clk_sys);
    bound(i, 10);
    chk(prog_job, exp_job(js));
    chk({busy_n, pass_n, fail_n}, 3'h3);
    @(posedge clk_sys);
    job_sel <= ~js;
    entry <= 1'b0;
    start_n <= 1'b1;
    @(negedge clk_sys);
    chk({led_y, prog_start}, 2'h2);
    for (i = 0; i < 300 && busy_n !== 1'b1; i++) @(negedge clk_sys);
    bound(i, 300);
    chk(prog_job, exp_job(js));
    chk({pass_n, fail_n}, {~okv, okv});
    @(negedge clk_sys);
    chk(led_y, 1'b0);
  endtask

  initial begin
    {cyc, stb, we, entry, adr, dat_i, job_sel, delay, ok, reset_n} = '0;
    sel = 4'hf;
    start_n = 1'b1;
    n_errors = 0;
    compares = 0;
    void'($urandom(32'hb48f4c40));
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    start_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    start_n <= 1'b1;
    wb(1'b0, `AJC_ADR_STATUS, 32'h0);
    chk(q[5:0], 6'h01);
    chk({busy_n, pass_n, fail_n, led_y, led_g, led_r}, 6'h38);
    wb(1'b1, `AJC_ADR_INT_ENABLE, 32'hf);
    wb(1'b0, `AJC_ADR_INT_ENABLE, 32'h0);
    chk(q, 32'hf);
    @(posedge clk_sys);
    entry <= 1'b1;
    wb(1'b0, `AJC_ADR_STATUS, 32'h0);
    chk(q[2:0], 3'h4);
    wb(1'b0, `AJC_ADR_INT_STATUS, 32'h0);
    chk(q, 32'h1);
    chk(irq, 1'b1);
    lamps(40);
    chk(n_starts, 32'd0);
    chk(32'(tg > 2), 32'd1);
    chk(32'(tr > 2), 32'd1);
    wb(1'b1, `AJC_ADR_INT_ENABLE, 32'h0);
    wb(1'b1, `AJC_ADR_INT_CLEAR, 32'hf);
    wb(1'b1, `AJC_ADR_INT_ENABLE, 32'hf);
    wb(1'b0, `AJC_ADR_INT_STATUS, 32'h0);
    chk(q, 32'h0);
    chk(irq, 1'b0);
    @(posedge clk_sys);
    entry <= 1'b0;
    for (k = 0; k < 10; k++) begin
      run_job(k[0], (k < 4) ? {2'(k), 2'(3 - k)} : 4'($urandom),
              (k < 4) ? k[1] : 1'($urandom), (k == 9) ? 8'd90 : 8'($urandom_range(1, 6)));
    end
    wb(1'b0, `AJC_ADR_INT_STATUS, 32'h0);
    chk(q, 32'he);
    chk(irq, 1'b1);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, `AJC_ADR_CTRL, 32'h4);
    wb(1'b0, `AJC_ADR_STATUS, 32'h0);
    chk(q[2:0], 3'h2);
    lamps(40);
    chk(tg, 32'd0);
    chk(tr, 32'd0);
    chk({led_g, led_r}, {~pass_n, ~fail_n});
    // host-side launch through the control register, ending in a failure
    @(posedge clk_sys);
    ok <= 1'b0;
    delay <= 8'd3;
    wb(1'b1, `AJC_ADR_CTRL, 32'h8);
    chk(busy_n, 1'b0);
    for (k = 0; k < 300 && busy_n !== 1'b1; k++) @(negedge clk_sys);
    bound(k, 300);
    chk({pass_n, fail_n}, 2'h2);
    @(posedge clk_sys);
    start_n <= 1'b0;
    repeat (HOLD + 5) @(posedge clk_sys);
    wb(1'b0, `AJC_ADR_STATUS, 32'h0);
    chk(q[2:0], 3'h4);
    chk(n_starts, 32'd11);
    // reset while autonomous with the start line held low and no job running, then register-driven mode changes
    reset_n <= 1'b0;
    @(posedge clk_sys);
    chk({busy_n, pass_n, fail_n, led_y, led_g, led_r, irq, prog_start}, 8'he0);
    reset_n <= 1'b1;
    start_n <= 1'b1;
    wb(1'b1, `AJC_ADR_CTRL, 32'h1);
    wb(1'b0, `AJC_ADR_STATUS, 32'h0);
    chk(q[5:0], 6'h02);
    wb(1'b1, `AJC_ADR_CTRL, 32'h2);
    wb(1'b0, `AJC_ADR_STATUS, 32'h0);
    chk(q[2:0], 3'h4);
    results();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    bound(1, 1);
  end
endmodule
